// File: core/ppg_pkg.sv
// Constants for the port P / port M pin control block: register map,
// reset values, field masks and interrupt layout.
// Assumes a 32-bit APB master and byte addresses on paddr.
//
// Behaviour
// R01: Open-drain pin drives zero, floats one
// R02: Open-drain select ignored on input pins
// R03: Reserved slot reads zero, ignores writes
// R04: Data register at 0x0258, resets zero, bit6 zero
// R05: GPIO output pin drives data bit
// R06: Data read: stored bit or pin level
// R07: Enabled PWM channel owns pins 4..0
// R08: Pin 5 owned by channel or shutdown
// R09: Pin interrupts in input or output mode
// R10: Level readback returns buffered pin levels
// R11: Level readback ignores writes
// R12: Direction bit one output, zero input
// R13: Enabled channel forces pins 4..0 output
// R14: Shutdown forces pin 5 input
// R15: Overrides never modify stored direction bits
// R16: Open-drain select one, reset push-pull
package ppg_pkg;

    // ==========================================================
    // Register byte addresses
    // ==========================================================
    localparam logic [11:0] OFS_PIN_DATA = 12'h0258;    // Port P data
    localparam logic [11:0] OFS_LEVEL_READBACK = 12'h025C; // Port P input levels
    localparam logic [11:0] OFS_DIRECTION = 12'h0260;   // Port P direction
    localparam logic [11:0] OFS_OPEN_DRAIN = 12'h0264;  // Port M wired-or select
    localparam logic [11:0] OFS_RESERVED = 12'h0268;    // Unimplemented slot
    localparam logic [11:0] OFS_IRQ_STATUS = 12'h026C;  // Sticky pin events
    localparam logic [11:0] OFS_IRQ_MASK = 12'h0270;    // Interrupt mask

    // ==========================================================
    // Field layout and reset values
    // ==========================================================
    localparam logic [7:0] PORTP_IMPL_MASK = 8'hBF;     // Bit 6 not present
    localparam int PWM_SHUTDOWN_BIT = 5;                // Pin with shutdown input
    localparam logic [7:0] RST_PIN_DATA = 8'h00;
    localparam logic [7:0] RST_DIRECTION = 8'h00;
    localparam logic [7:0] RST_OPEN_DRAIN = 8'h00;      // Push-pull after reset
    localparam logic [7:0] RST_IRQ_STATUS = 8'h00;
    localparam logic [7:0] RST_IRQ_MASK = 8'h00;
    localparam logic [7:0] RESERVED_VALUE = 8'h00;
    localparam logic [31:0] BUS_ZERO = 32'h0000_0000;

endpackage

// File: core/ppg_port.sv
// Port P pin control with PWM overrides, pin-event interrupt, and the
// port M wired-or output stage, behind an APB slave.
// Assumes pin inputs already synchronous to clk; port M data and
// direction come from the neighbouring port logic.
`timescale 1ns/1ps

module ppg_port #(
    parameter int PORTM_W = 6 // Width of the neighbouring wired-or port
) (
    // Clock and synchronous reset
    input wire logic clk,
    input wire logic resetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Port P pins
    input wire logic [7:0] pp_i,
    output logic [7:0] pp_o,
    output logic [7:0] pp_oe,
    // PWM unit
    input wire logic [5:0] pwm_chan_en,
    input wire logic pwm_shutdown_en,
    input wire logic [5:0] pwm_out,
    // Port M wired-or stage
    input wire logic [PORTM_W-1:0] pm_val,
    input wire logic [PORTM_W-1:0] pm_dir,
    output logic [PORTM_W-1:0] pm_o,
    output logic [PORTM_W-1:0] pm_oe,
    // Level interrupt
    output logic irq
);

    // ==========================================================
    // Elaboration check
    // ==========================================================
    // Select register is one byte wide, so the port cannot exceed 8 pins
    if (PORTM_W < 1 || PORTM_W > 8) begin : g_bad_width
        $error("PORTM_W must be between 1 and 8");
    end

    // ==========================================================
    // State
    // ==========================================================
    logic [7:0] data_r;         // Port P data bits
    logic [7:0] dir_r;          // Port P direction bits, never touched by overrides
    logic [7:0] od_r;           // Port M wired-or select
    logic [7:0] stat_r;         // Sticky pin-event flags
    logic [7:0] mask_r;         // Interrupt mask
    logic [7:0] pin_prev_r;     // Last pin level for change detection
    logic [31:0] prdata_r;      // Read data latched in setup phase
    logic rd_stat_r;            // Pending access is a status read
    logic [7:0] stat_nxt;

    // ==========================================================
    // APB decode
    // ==========================================================
    // Address compare used for both hit detect and write strobes
    function automatic logic at(input logic [11:0] a, input logic [11:0] ofs);
        at = (a == ofs);
    endfunction

    wire setup_ph = psel & ~penable;            // First cycle of a transfer
    wire access_ph = psel & penable;            // Completing cycle
    wire addr_hit = at(paddr, ppg_pkg::OFS_PIN_DATA) | at(paddr, ppg_pkg::OFS_LEVEL_READBACK)
                  | at(paddr, ppg_pkg::OFS_DIRECTION) | at(paddr, ppg_pkg::OFS_OPEN_DRAIN)
                  | at(paddr, ppg_pkg::OFS_RESERVED) | at(paddr, ppg_pkg::OFS_IRQ_STATUS)
                  | at(paddr, ppg_pkg::OFS_IRQ_MASK);
    wire wr_go = access_ph & pwrite;            // Write commits at this edge
    wire wr_data = wr_go & at(paddr, ppg_pkg::OFS_PIN_DATA);
    wire wr_dir = wr_go & at(paddr, ppg_pkg::OFS_DIRECTION);
    wire wr_od = wr_go & at(paddr, ppg_pkg::OFS_OPEN_DRAIN);
    wire wr_mask = wr_go & at(paddr, ppg_pkg::OFS_IRQ_MASK);
    wire rd_setup = setup_ph & ~pwrite;         // Read data sampled now

    // Zero wait states; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = access_ph & ~addr_hit;
    assign prdata = prdata_r;

    // ==========================================================
    // Pin direction and ownership
    // ==========================================================
    wire [7:0] pin_lvl = pp_i & ppg_pkg::PORTP_IMPL_MASK;           // R10
    // Bit 6 absent, so both masks carry zeros there
    wire [7:0] pwm_own = {2'b00, pwm_chan_en[5] | pwm_shutdown_en,  // R08
                          pwm_chan_en[4:0]};                        // R07
    wire [7:0] pwm_drive = {2'b00, pwm_chan_en[5] & ~pwm_shutdown_en, // R14
                            pwm_chan_en[4:0]};                      // R13
    wire [7:0] gpio_out = dir_r & ~pwm_own & ppg_pkg::PORTP_IMPL_MASK; // R12
    // Read mux keeps the stored direction, not the overridden one
    wire [7:0] data_view = ((dir_r & data_r) | (~dir_r & pin_lvl))
                         & ppg_pkg::PORTP_IMPL_MASK;                // R06

    // Enable: PWM driving or GPIO output; value from PWM or data bit
    assign pp_oe = pwm_drive | gpio_out;
    assign pp_o = ((pwm_own & {2'b00, pwm_out}) | (~pwm_own & data_r))
                & ppg_pkg::PORTP_IMPL_MASK;                         // R05

    // ==========================================================
    // Port M wired-or stage
    // ==========================================================
    // Open drain: only a zero is driven, a one floats
    assign pm_oe = pm_dir & (~od_r[PORTM_W-1:0] | ~pm_val);         // R01 R02 R16
    assign pm_o = pm_val & ~od_r[PORTM_W-1:0];                      // R01

    // ==========================================================
    // Pin events and interrupt
    // ==========================================================
    // Any level change counts, regardless of direction or owner
    wire [7:0] pin_evt = (pin_lvl ^ pin_prev_r);                    // R09
    // Clear only bits returned by the read, so an event is never lost
    wire [7:0] stat_clr = (rd_stat_r & access_ph & ~pwrite) ? prdata_r[7:0] : 8'h00;
    assign stat_nxt = (stat_r & ~stat_clr) | pin_evt;
    assign irq = |(stat_r & mask_r);

    // ==========================================================
    // Read data selection
    // ==========================================================
    logic [7:0] rd_sel;
    always_comb begin
        // Unmapped addresses yield zero
        rd_sel = 8'h00;
        if (at(paddr, ppg_pkg::OFS_PIN_DATA)) begin
            rd_sel = data_view;                                     // R06
        end else if (at(paddr, ppg_pkg::OFS_LEVEL_READBACK)) begin
            rd_sel = pin_lvl;                                       // R10
        end else if (at(paddr, ppg_pkg::OFS_DIRECTION)) begin
            rd_sel = dir_r & ppg_pkg::PORTP_IMPL_MASK;              // R15
        end else if (at(paddr, ppg_pkg::OFS_OPEN_DRAIN)) begin
            rd_sel = od_r;
        end else if (at(paddr, ppg_pkg::OFS_RESERVED)) begin
            rd_sel = ppg_pkg::RESERVED_VALUE;                       // R03
        end else if (at(paddr, ppg_pkg::OFS_IRQ_STATUS)) begin
            rd_sel = stat_r;
        end else if (at(paddr, ppg_pkg::OFS_IRQ_MASK)) begin
            rd_sel = mask_r;
        end
    end

    // ==========================================================
    // Configuration registers
    // ==========================================================
    // Level readback and reserved slot have no storage: writes vanish
    // so no write strobe is decoded for either offset
    always_ff @(posedge clk) begin // R03 R11
        if (!resetn) begin
            data_r <= ppg_pkg::RST_PIN_DATA;                        // R04
            dir_r <= ppg_pkg::RST_DIRECTION;
            od_r <= ppg_pkg::RST_OPEN_DRAIN;                        // R16
            mask_r <= ppg_pkg::RST_IRQ_MASK;
        end else begin
            if (wr_data) begin
                data_r <= pwdata[7:0] & ppg_pkg::PORTP_IMPL_MASK;   // R04
            end
            if (wr_dir) begin
                dir_r <= pwdata[7:0] & ppg_pkg::PORTP_IMPL_MASK;    // R15
            end
            if (wr_od) begin
                od_r <= pwdata[7:0];
            end
            if (wr_mask) begin
                mask_r <= pwdata[7:0];
            end
        end
    end

    // Event flags and pin history
    always_ff @(posedge clk) begin
        if (!resetn) begin
            stat_r <= ppg_pkg::RST_IRQ_STATUS;
            pin_prev_r <= 8'h00;
        end else begin
            stat_r <= stat_nxt;                                     // R09
            pin_prev_r <= pin_lvl;
        end
    end

    // Read data latched in setup, held through access
    always_ff @(posedge clk) begin
        if (!resetn) begin
            prdata_r <= ppg_pkg::BUS_ZERO;
            rd_stat_r <= 1'b0;
        end else if (rd_setup) begin
            prdata_r <= {24'h00_0000, rd_sel};
            rd_stat_r <= at(paddr, ppg_pkg::OFS_IRQ_STATUS);
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    // All checks run on the one clock and rest while reset is held
    // Bus checks follow one transfer from setup to access edge, writes to the edge after
    // Pin checks are combinational and hold in every cycle
    // Only the reset check below looks inside reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_rd_setup(logic [11:0] ofs);
        psel && !penable && !pwrite && paddr == ofs;
    endsequence

    sequence s_wr_access(logic [11:0] ofs);
        psel && penable && pwrite && paddr == ofs;
    endsequence

    sequence s_rd_access(logic [11:0] ofs);
        psel && penable && !pwrite && paddr == ofs;
    endsequence

    a_data_read_mux: assert property ( // R06
        s_rd_setup(ppg_pkg::OFS_PIN_DATA) |=> prdata[7:0] == $past(data_view) && prdata[6] == 1'b0)
        else $error("data read mux wrong");
    a_rsvd_read_zero: assert property ( // R03
        s_rd_setup(ppg_pkg::OFS_RESERVED) |=> prdata == 32'h0000_0000)
        else $error("reserved slot not zero");
    a_level_read_back: assert property ( // R10
        s_rd_setup(ppg_pkg::OFS_LEVEL_READBACK) |=> prdata[7:0] == ($past(pp_i) & 8'hBF))
        else $error("level readback wrong");
    a_level_wr_ignored: assert property ( // R11
        s_wr_access(ppg_pkg::OFS_LEVEL_READBACK) |=> $stable(data_r) && $stable(dir_r) && $stable(od_r))
        else $error("level readback write had effect");
    a_dir_only_write: assert property ( // R15
        !(psel && penable && pwrite && paddr == ppg_pkg::OFS_DIRECTION) |=> dir_r == $past(dir_r))
        else $error("direction changed without write");
    a_pwm_force_out: assert property ( // R13
        (pwm_chan_en[4:0] & ~pp_oe[4:0]) == 5'h00)
        else $error("enabled channel pin not output");
    a_shutdown_input: assert property ( // R14
        pwm_shutdown_en |-> !pp_oe[5])
        else $error("shutdown pin driven");
    a_gpio_drive_val: assert property ( // R05
        ((pp_o ^ data_r) & dir_r & ~pwm_own & 8'hBF) == 8'h00)
        else $error("gpio pin value differs from data");
    a_od_drive_low: assert property ( // R01
        (od_r[PORTM_W-1:0] & pm_oe & pm_val) == '0)
        else $error("open-drain pin drove high");
    a_od_input_quiet: assert property ( // R02
        (~pm_dir & pm_oe) == '0)
        else $error("input pin driven");
    a_evt_sets_flag: assert property ( // R09
        (pin_evt != 8'h00) |=> (stat_r & $past(pin_evt)) == $past(pin_evt))
        else $error("pin event lost");
    a_data_reset_zero: assert property (disable iff (1'b0) // R04
        !resetn |=> data_r == 8'h00 && dir_r == 8'h00 && od_r == 8'h00)
        else $error("reset values wrong");

    // ==========================================================
    // Assertions: register writes and reads
    // ==========================================================
    // A write commits at its access edge and shows one cycle later
    a_data_write_lands: assert property ( // R04
        s_wr_access(ppg_pkg::OFS_PIN_DATA) |=> data_r == ($past(pwdata[7:0]) & 8'hBF))
        else $error("data write lost");

    // Stored direction takes the written value, bit 6 dropped
    a_dir_write_lands: assert property ( // R12
        s_wr_access(ppg_pkg::OFS_DIRECTION) |=> dir_r == ($past(pwdata[7:0]) & 8'hBF))
        else $error("direction write lost");

    // Select keeps all eight bits, upper ones unused
    a_od_write_lands: assert property ( // R16
        s_wr_access(ppg_pkg::OFS_OPEN_DRAIN) |=> od_r == $past(pwdata[7:0]))
        else $error("open-drain write lost");

    // Reserved slot has no storage behind it
    a_rsvd_wr_ignored: assert property ( // R03
        s_wr_access(ppg_pkg::OFS_RESERVED) |=> $stable(data_r) && $stable(dir_r) && $stable(od_r)
            && $stable(mask_r))
        else $error("reserved write had effect");

    // Readback of direction is the stored bit, override or not
    a_dir_reads_back: assert property ( // R15
        s_rd_setup(ppg_pkg::OFS_DIRECTION) |=> prdata[7:0] == $past(dir_r))
        else $error("direction readback wrong");

    // Registers are one byte wide, so the upper lanes stay zero
    a_rd_upper_zero: assert property ( // R06
        (psel && penable && !pwrite) |-> prdata[31:8] == 24'h00_0000)
        else $error("read upper bits not zero");

    // A mapped register never answers with an error
    a_data_no_error: assert property ( // R06
        s_rd_access(ppg_pkg::OFS_PIN_DATA) |-> !pslverr)
        else $error("data read flagged error");

    // ==========================================================
    // Assertions: port P pins
    // ==========================================================
    // A GPIO output pin not owned by the PWM is driven
    a_gpio_out_en: assert property ( // R12
        ((dir_r & ~pwm_own & 8'hBF) & ~pp_oe) == 8'h00)
        else $error("gpio output pin not driven");

    // An input pin stays released unless the PWM drives it
    a_gpio_in_quiet: assert property ( // R12
        (~dir_r & ~pwm_drive & pp_oe) == 8'h00)
        else $error("gpio input pin driven");

    // Pin 6 does not exist and must never be driven
    a_bit6_quiet: assert property ( // R04
        !pp_oe[6] && !pp_o[6])
        else $error("absent pin 6 active");

    // Pin 7 has no PWM channel: plain GPIO only
    a_pin7_gpio_only: assert property ( // R05
        pp_oe[7] == dir_r[7] && pp_o[7] == data_r[7])
        else $error("pin 7 not plain gpio");

    // An enabled channel puts its waveform on pins 4..0
    a_pwm_pin_value: assert property ( // R07
        ((pp_o[4:0] ^ pwm_out[4:0]) & pwm_chan_en[4:0]) == 5'h00)
        else $error("pwm value not on pin");

    // Pin 5 belongs to the PWM for channel or shutdown
    a_pin5_owner: assert property ( // R08
        (pwm_chan_en[5] || pwm_shutdown_en) |-> pp_o[5] == pwm_out[5])
        else $error("pin 5 owner wrong");

    // Without shutdown an enabled channel 5 drives its pin
    a_pin5_pwm_drive: assert property ( // R14
        (pwm_chan_en[5] && !pwm_shutdown_en) |-> pp_oe[5])
        else $error("pin 5 channel not driven");

    // ==========================================================
    // Assertions: port M output stage
    // ==========================================================
    // Push-pull output pins are always driven
    a_pp_drive_both: assert property ( // R16
        (~od_r[PORTM_W-1:0] & pm_dir & ~pm_oe) == '0)
        else $error("push-pull pin released");

    // Push-pull pins carry the neighbour's value
    a_pp_value: assert property ( // R16
        ((pm_o ^ pm_val) & ~od_r[PORTM_W-1:0]) == '0)
        else $error("push-pull value wrong");

    // Open-drain pins never present a high level
    a_od_never_high: assert property ( // R01
        (od_r[PORTM_W-1:0] & pm_o) == '0)
        else $error("open-drain pin high");

    // Open-drain output pins pull low for a zero
    a_od_pull_low: assert property ( // R01
        (od_r[PORTM_W-1:0] & pm_dir & ~pm_val & ~pm_oe) == '0)
        else $error("open-drain zero released");

    // ==========================================================
    // Assertions: pin events
    // ==========================================================
    // Flags only appear after a pin event
    a_stat_no_spur: assert property ( // R09
        (pin_evt == 8'h00) |=> (stat_r & ~$past(stat_r)) == 8'h00)
        else $error("flag set without event");

    // A status read clears what it returned
    a_stat_read_clear: assert property ( // R09
        (s_rd_setup(ppg_pkg::OFS_IRQ_STATUS) ##1 s_rd_access(ppg_pkg::OFS_IRQ_STATUS) ##0 (pin_evt == 8'h00))
        |=> (stat_r & $past(prdata[7:0])) == 8'h00)
        else $error("status read did not clear");

    // An event in the clearing cycle wins over the clear
    a_set_beats_clear: assert property ( // R09
        s_rd_access(ppg_pkg::OFS_IRQ_STATUS) |=> (stat_r & $past(pin_evt)) == $past(pin_evt))
        else $error("event lost to clear");

    // Mask takes the written byte as it stands
    a_mask_write_lands: assert property ( // R09
        s_wr_access(ppg_pkg::OFS_IRQ_MASK) |=> mask_r == $past(pwdata[7:0]))
        else $error("mask write lost");

endmodule // ppg_port

// File: dv/ppg_pins_model.sv
// Port P pin wires: the level each pin settles to from the block's drive
// and from whatever the board puts on the pin.
// Assumes no pull devices, so an undriven pin shows the outside level.
`timescale 1ns/1ps

module ppg_pins_model (
    input wire logic [7:0] pp_o,
    input wire logic [7:0] pp_oe,
    input wire logic [7:0] ext,
    output logic [7:0] pp_i
);
    // ========
    // Pin wire
    // ========
    // Driven pins read back the block's value, released pins the board's
    assign pp_i = (pp_oe & pp_o) | (~pp_oe & ext);
endmodule // ppg_pins_model

// File: dv/ppg_port_tb_top.sv
// Self-checking bench for the port P pin control block over APB.
// Assumes the pin model beside it and a 25 MHz clock.
`timescale 1ns/1ps

module ppg_port_tb_top;
    // =======
    // Signals
    // =======
    logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, pwm_shutdown_en = 0, pready, pslverr, irq;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic [7:0] ext = 0, pp_i, pp_o, pp_oe;
    logic [5:0] pwm_chan_en = 0, pwm_out = 0, pm_val = 0, pm_dir = 0, pm_o, pm_oe;
    logic e;
    int fail_count = 0, n_compared = 0, m_data = 0, m_dir = 0, m_od = 0, n;

    ppg_port dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pp_i(pp_i), .pp_o(pp_o), .pp_oe(pp_oe), .pwm_chan_en(pwm_chan_en),
        .pwm_shutdown_en(pwm_shutdown_en), .pwm_out(pwm_out), .pm_val(pm_val), .pm_dir(pm_dir),
        .pm_o(pm_o), .pm_oe(pm_oe), .irq(irq));
    ppg_pins_model pins (.pp_o(pp_o), .pp_oe(pp_oe), .ext(ext), .pp_i(pp_i));

    // 40 ns clock
    initial forever #20 clk = ~clk;

    // =================
    // Expected behaviour
    // =================
    // Drive enables: direction bit or enabled channel, shutdown releases pin 5
    function automatic logic [7:0] oe_e();
        logic [7:0] v;
        v = m_dir[7:0] | {2'b00, pwm_chan_en};
        v[5] = v[5] & ~pwm_shutdown_en;
        return v & 8'hBF;
    endfunction
    // Pin values: PWM owns a pin while its channel, or shutdown on pin 5, is on
    function automatic logic [7:0] o_e();
        logic [7:0] v;
        v = m_data[7:0];
        for (int i = 0; i < 6; i++) begin
            if (pwm_chan_en[i] || (i == 5 && pwm_shutdown_en)) v[i] = pwm_out[i];
        end
        return v & 8'hBF;
    endfunction
    // Level on the wires, bit 6 absent
    function automatic logic [7:0] lvl_e();
        return ((oe_e() & o_e()) | (~oe_e() & ext)) & 8'hBF;
    endfunction

    // =====
    // Tasks
    // =====
    task automatic close_out();
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        n_compared++;
        if (g !== x) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
        end
    endtask
    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        for (k = 0; k < 20; k++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (k == 20) begin
            fail_count++;
            close_out();
        end
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] x);
        apb(0, a, 32'h0000_0000);
        chk(nm, x, r);
    endtask

    // =============
    // Main sequence
    // =============
    initial begin
        void'($urandom(450));
        repeat (5) @(posedge clk);
        resetn <= 1;
        // Reset values, pins all undriven and low
        rd("data", ppg_pkg::OFS_PIN_DATA, 32'h0000_0000);
        rd("dir", ppg_pkg::OFS_DIRECTION, 32'h0000_0000);
        rd("od", ppg_pkg::OFS_OPEN_DRAIN, 32'h0000_0000);
        chk("irq", 0, irq);
        // Random register and pin mixes, PWM held off for the first few
        for (n = 0; n < 24; n++) begin
            m_data = $urandom & 8'hFF;
            m_dir = $urandom & 8'hBF;
            m_od = $urandom & 8'h3F;
            apb(1, ppg_pkg::OFS_PIN_DATA, m_data);
            apb(1, ppg_pkg::OFS_DIRECTION, m_dir);
            apb(1, ppg_pkg::OFS_OPEN_DRAIN, m_od);
            @(posedge clk);
            ext <= $urandom;
            pwm_chan_en <= (n < 6) ? 6'h00 : 6'($urandom);
            pwm_shutdown_en <= (n < 6) ? 1'b0 : 1'($urandom);
            pwm_out <= $urandom;
            pm_val <= $urandom;
            pm_dir <= $urandom;
            @(negedge clk);
            chk("pp_oe", oe_e(), pp_oe);
            chk("pp_o", o_e(), pp_o);
            chk("pm_oe", pm_dir & ~(m_od[5:0] & pm_val), pm_oe);
            chk("pm_o", pm_val & ~m_od[5:0] & pm_oe, pm_o & pm_oe);
            rd("data", ppg_pkg::OFS_PIN_DATA, ((m_dir & m_data) | (~m_dir & lvl_e())) & 8'hBF);
            rd("level", ppg_pkg::OFS_LEVEL_READBACK, lvl_e());
            rd("dir", ppg_pkg::OFS_DIRECTION, m_dir);
            rd("od", ppg_pkg::OFS_OPEN_DRAIN, m_od);
            apb(1, ppg_pkg::OFS_LEVEL_READBACK, ~lvl_e());
            rd("level_wr", ppg_pkg::OFS_LEVEL_READBACK, lvl_e());
        end
        // Reserved slot and an unmapped address
        apb(1, ppg_pkg::OFS_RESERVED, 32'h0000_00FF);
        rd("rsvd", ppg_pkg::OFS_RESERVED, 32'h0000_0000);
        rd("unmapped", 12'h2FC, 32'h0000_0000);
        chk("pslverr", 1, e);
        // Interrupts: quiet pins, drop old events, then one input and one output pin move
        @(posedge clk);
        pwm_chan_en <= 0;
        pwm_shutdown_en <= 0;
        ext <= 0;
        apb(1, ppg_pkg::OFS_DIRECTION, 32'h0000_0080);
        apb(1, ppg_pkg::OFS_PIN_DATA, 32'h0000_0000);
        repeat (3) @(posedge clk);
        apb(0, ppg_pkg::OFS_IRQ_STATUS, 0);
        apb(1, ppg_pkg::OFS_IRQ_MASK, 32'h0000_00BF);
        apb(1, ppg_pkg::OFS_PIN_DATA, 32'h0000_0080);
        ext <= 8'h01;
        repeat (3) @(negedge clk);
        chk("irq", 1, irq);
        rd("status", ppg_pkg::OFS_IRQ_STATUS, 32'h0000_0081);
        @(negedge clk);
        chk("irq", 0, irq);
        // Masked event stays latched but raises nothing
        apb(1, ppg_pkg::OFS_IRQ_MASK, 32'h0000_0000);
        ext <= 8'h00;
        repeat (3) @(negedge clk);
        chk("irq", 0, irq);
        rd("status", ppg_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
        close_out();
    end
endmodule // ppg_port_tb_top
